// ===== interrupt_global_control.sv
// Global interrupt control register with AXI4-Lite access and proximity timer
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "irq_ctl_defines.svh"
// Overview of operation
// (R1) Shadow bit set: single vector uses shadow set
// (R2) Multi-vector bit selects multi or single mode
// (R3) Threshold 000 disables timer; else priority <= value
// (R4) Threshold 001: only priority 1 starts timer
// (R5) Per-input polarity bit: one rising, zero falling
// (R6) Unimplemented bits read zero, ignore writes
// (R7) Clear, set, invert aliases at +4, +8, +C
// (R8) Aliases clear/set/toggle selected bits; base reads value
module interrupt_global_control (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [4:0]  ext_irq_in,
    input  wire logic        core_irq_valid,
    input  wire logic [2:0]  core_irq_priority,
    output logic             multi_vector_mode,
    output logic             single_vector_shadow,
    output logic             proximity_timer_running,
    output logic [4:0]       ext_irq_event,
    output logic             irq
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    irq_ctl_pkg::word_t      ctl_r;
    irq_ctl_pkg::word_t      ctl_nxt;
    logic [5:0]              stat_r;
    logic [5:0]              stat_nxt;
    logic [5:0]              ien_r;
    logic [5:0]              ien_nxt;
    irq_ctl_pkg::word_t      ptmr_reload_r;
    irq_ctl_pkg::word_t      ptmr_reload_nxt;
    irq_ctl_pkg::word_t      ptmr_cnt_r;
    irq_ctl_pkg::word_t      ptmr_cnt_nxt;
    irq_ctl_pkg::ptmr_state_e pt_state_r;
    irq_ctl_pkg::ptmr_state_e pt_state_nxt;
    logic [11:0]             awaddr_r;
    logic [11:0]             awaddr_nxt;
    logic                    aw_have_r;
    logic                    aw_have_nxt;
    logic [31:0]             wdata_r;
    logic [31:0]             wdata_nxt;
    logic [3:0]              wstrb_r;
    logic [3:0]              wstrb_nxt;
    logic                    w_have_r;
    logic                    w_have_nxt;
    logic                    bvalid_r;
    logic                    bvalid_nxt;
    logic [1:0]              bresp_r;
    logic [1:0]              bresp_nxt;
    logic                    rvalid_r;
    logic                    rvalid_nxt;
    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;
    logic [1:0]              rresp_r;
    logic [1:0]              rresp_nxt;
    logic [4:0]              evt_r;
    logic [4:0]              evt_nxt;

    irq_cfg_if cfg_bus ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge, used by every writable register
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Whether a priority may start the proximity timer
    function automatic logic prio_starts(input logic [2:0] thr, input logic [2:0] prio);
        if (thr == 3'h0)
            prio_starts = 1'b0;                 // (R3)
        else if (thr == 3'h1)
            prio_starts = (prio == 3'h1);       // (R4)
        else
            prio_starts = (prio <= thr);        // (R3)
    endfunction

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = ({a[11:2], 2'b00} <= `PTMR_OFS);
    endfunction

    // ------------------------------------------------------------
    // Edge detection on external inputs
    // ------------------------------------------------------------
    assign cfg_bus.polarity = ctl_r[4:0];       // (R5)

    ext_edge_det u_det (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .ext_irq_in (ext_irq_in),
        .cfg        (cfg_bus.det)
    );

    // ------------------------------------------------------------
    // Write channel handling
    // ------------------------------------------------------------
    logic       wr_go;
    logic [31:0] wmask;
    logic [2:0] thr;
    logic       pt_start;
    logic       pt_expire;

    // Address and data accepted in either order; answer once both are held
    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready  = ~w_have_r & ~bvalid_r;
    assign wr_go         = aw_have_r & w_have_r & ~bvalid_r;
    assign wmask         = lane_mask(wstrb_r) & wdata_r;
    assign thr           = ctl_r[`TPC_MSB:`TPC_LSB];
    assign pt_start      = core_irq_valid & prio_starts(thr, core_irq_priority);

    always_comb begin
        awaddr_nxt  = awaddr_r;
        aw_have_nxt = aw_have_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        w_have_nxt  = w_have_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_nxt  = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
            w_have_nxt = 1'b1;
        end
        if (wr_go) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = known_addr(awaddr_r) ? `AXI_OKAY : `AXI_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    // Alias writes touch only the bits written as one; holes stay zero
    always_comb begin
        ctl_nxt         = ctl_r;
        ien_nxt         = ien_r;
        ptmr_reload_nxt = ptmr_reload_r;
        stat_nxt        = stat_r;
        if (wr_go) begin
            unique case ({2'b00, awaddr_r[11:2]})
                `GCTL_OFS >> 2:
                    ctl_nxt = ((ctl_r & ~lane_mask(wstrb_r)) | wmask)
                              & `GCTL_IMPL_MASK;                       // (R6)
                `GCTL_CLR_OFS >> 2: ctl_nxt = ctl_r & ~wmask;           // (R7) (R8)
                `GCTL_SET_OFS >> 2:
                    ctl_nxt = (ctl_r | wmask) & `GCTL_IMPL_MASK;        // (R7) (R8)
                `GCTL_INV_OFS >> 2:
                    ctl_nxt = (ctl_r ^ wmask) & `GCTL_IMPL_MASK;        // (R7) (R8)
                `IEN_OFS >> 2:  ien_nxt = (ien_r & ~{6{wstrb_r[0]}}) | wmask[5:0];
                `ICLR_OFS >> 2: stat_nxt = stat_r & ~wmask[5:0];
                `PTMR_OFS >> 2:
                    ptmr_reload_nxt = (ptmr_reload_r & ~lane_mask(wstrb_r)) | wmask;
                default: ;
            endcase
        end
        // Events win over a clear in the same cycle
        stat_nxt = stat_nxt | {pt_expire, cfg_bus.edge_hit};
    end

    // ------------------------------------------------------------
    // Proximity timer
    // ------------------------------------------------------------
    // Counts down from the reload value once a qualifying interrupt arrives
    assign pt_expire = (pt_state_r == irq_ctl_pkg::PT_DONE);

    always_comb begin
        pt_state_nxt = pt_state_r;
        ptmr_cnt_nxt = ptmr_cnt_r;
        unique case (pt_state_r)
            irq_ctl_pkg::PT_IDLE: begin
                if (pt_start) begin                         // (R3) (R4)
                    ptmr_cnt_nxt = ptmr_reload_r;
                    pt_state_nxt = irq_ctl_pkg::PT_RUN;
                end
            end
            irq_ctl_pkg::PT_RUN: begin
                if (thr == 3'h0) begin
                    pt_state_nxt = irq_ctl_pkg::PT_IDLE;    // (R3)
                end else if (ptmr_cnt_r == 32'h0000_0000) begin
                    pt_state_nxt = irq_ctl_pkg::PT_DONE;
                end else begin
                    ptmr_cnt_nxt = ptmr_cnt_r - 32'h0000_0001;
                end
            end
            irq_ctl_pkg::PT_DONE: pt_state_nxt = irq_ctl_pkg::PT_IDLE;
            default: pt_state_nxt = irq_ctl_pkg::PT_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~rvalid_r;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `AXI_OKAY;
            unique case ({2'b00, s_axi_araddr[11:2]})
                `GCTL_OFS >> 2:  rdata_nxt = ctl_r;                     // (R8)
                `ISTAT_OFS >> 2: rdata_nxt = {26'h0000000, stat_r};
                `IEN_OFS >> 2:   rdata_nxt = {26'h0000000, ien_r};
                `PTMR_OFS >> 2:  rdata_nxt = ptmr_reload_r;
                default: begin
                    // Alias and clear addresses are write-only
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = known_addr(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    assign evt_nxt = cfg_bus.edge_hit;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_r         <= `GCTL_RESET;
            stat_r        <= 6'h00;
            ien_r         <= 6'h00;
            ptmr_reload_r <= `PTMR_RESET;
            ptmr_cnt_r    <= 32'h0000_0000;
            pt_state_r    <= irq_ctl_pkg::PT_IDLE;
            awaddr_r      <= 12'h000;
            aw_have_r     <= 1'b0;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            w_have_r      <= 1'b0;
            bvalid_r      <= 1'b0;
            bresp_r       <= 2'h0;
            rvalid_r      <= 1'b0;
            rdata_r       <= 32'h0000_0000;
            rresp_r       <= 2'h0;
            evt_r         <= 5'h00;
        end else begin
            ctl_r         <= ctl_nxt;
            stat_r        <= stat_nxt;
            ien_r         <= ien_nxt;
            ptmr_reload_r <= ptmr_reload_nxt;
            ptmr_cnt_r    <= ptmr_cnt_nxt;
            pt_state_r    <= pt_state_nxt;
            awaddr_r      <= awaddr_nxt;
            aw_have_r     <= aw_have_nxt;
            wdata_r       <= wdata_nxt;
            wstrb_r       <= wstrb_nxt;
            w_have_r      <= w_have_nxt;
            bvalid_r      <= bvalid_nxt;
            bresp_r       <= bresp_nxt;
            rvalid_r      <= rvalid_nxt;
            rdata_r       <= rdata_nxt;
            rresp_r       <= rresp_nxt;
            evt_r         <= evt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_bvalid            = bvalid_r;
    assign s_axi_bresp             = bresp_r;
    assign s_axi_rvalid            = rvalid_r;
    assign s_axi_rdata             = rdata_r;
    assign s_axi_rresp             = rresp_r;
    assign multi_vector_mode       = ctl_r[`MULTI_VECTOR_ENABLE_BIT];                  // (R2)
    assign single_vector_shadow    = ctl_r[`SHADOW_BIT] & ~ctl_r[`MULTI_VECTOR_ENABLE_BIT]; // (R1)
    assign proximity_timer_running = (pt_state_r == irq_ctl_pkg::PT_RUN);
    assign ext_irq_event           = evt_r;
    assign irq                     = |(stat_r & ien_r);
endmodule

// ===== irq_ctl_defines.svh
// Register offsets, field positions, reset values and AXI response codes
`ifndef IRQ_CTL_DEFINES_SVH
`define IRQ_CTL_DEFINES_SVH

`define GCTL_OFS        12'h000
`define GCTL_CLR_OFS    12'h004
`define GCTL_SET_OFS    12'h008
`define GCTL_INV_OFS    12'h00c
`define ISTAT_OFS       12'h010
`define IEN_OFS         12'h014
`define ICLR_OFS        12'h018
`define PTMR_OFS        12'h01c

`define SHADOW_BIT      16
`define MULTI_VECTOR_ENABLE_BIT        12
`define TPC_LSB         8
`define TPC_MSB         10
`define EXT_COUNT       5
`define GCTL_IMPL_MASK  32'h0001_171f
`define GCTL_RESET      32'h0000_0000
`define PTMR_RESET      32'h0000_0000
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10

`endif

// ===== irq_ctl_pkg.sv
// Types shared by the global interrupt control block
package irq_ctl_pkg;
    typedef enum logic [2:0] {
        PT_IDLE = 3'b001,
        PT_RUN  = 3'b010,
        PT_DONE = 3'b100
    } ptmr_state_e;
    typedef logic [31:0] word_t;
endpackage

// ===== irq_cfg_if.sv
// Configuration bundle between register file and edge detector
`timescale 1ns/1ps
interface irq_cfg_if;
    logic [4:0] polarity;
    logic [4:0] edge_hit;
    modport ctl (output polarity, input edge_hit);
    modport det (input polarity, output edge_hit);
endinterface

// ===== ext_edge_det.sv
// Synchroniser and polarity-selectable edge detector for external interrupts
`timescale 1ns/1ps
`include "irq_ctl_defines.svh"
module ext_edge_det (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  ext_irq_in,
    irq_cfg_if.det           cfg
);
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic [4:0] last_r;
    logic [4:0] meta_nxt;
    logic [4:0] sync_nxt;
    logic [4:0] last_nxt;
    logic [2:0] fill_r;
    logic [2:0] fill_nxt;

    // Two stages before use; the second stage and its one-cycle-older copy feed the detector
    // Fill marker holds detection off until history holds real pin levels,
    // so a pin idling high gives no false edge after reset; an edge in
    // the cycle before the first sample after reset is lost; later edges are all seen
    always_comb begin
        meta_nxt = ext_irq_in;
        sync_nxt = meta_r;
        last_nxt = sync_r;
        fill_nxt = {fill_r[1:0], 1'b1};
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
            last_r <= 5'h00;
            fill_r <= 3'h0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
            fill_r <= fill_nxt;
        end
    end

    // One polarity bit per input: one = rising, zero = falling
    genvar i;
    generate
        for (i = 0; i < `EXT_COUNT; i++) begin : g_det
            assign cfg.edge_hit[i] = fill_r[2] & (cfg.polarity[i]  // (R5)
                                     ? (sync_r[i] & ~last_r[i])
                                     : (~sync_r[i] & last_r[i]));
        end
    endgenerate
endmodule

// ===== core_vector_model.sv
// Processor core model that takes interrupts from the controller
`timescale 1ns/1ps
module core_vector_model (
    output logic       core_irq_valid,
    output logic [2:0] core_irq_priority,
    input  wire logic  ref_clk
);
    // Idle from time zero
    initial begin
        core_irq_valid    = 1'b0;
        core_irq_priority = 3'h0;
    end

    // Take one interrupt after a gap; valid stands for one cycle only
    task automatic take(input logic [2:0] p, input logic [1:0] gap);
        repeat (gap) @(posedge ref_clk);
        core_irq_valid    <= 1'b1;
        core_irq_priority <= p;
        @(posedge ref_clk);
        core_irq_valid    <= 1'b0;
        core_irq_priority <= ~p;  // Stale priority must not pass as live
    endtask
endmodule

// ===== interrupt_global_control_checker.sv
// Concurrent checks on the ports of the global interrupt control block
`timescale 1ns/1ps
module interrupt_global_control_checker (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       core_irq_valid,
    input wire logic       multi_vector_mode,
    input wire logic       single_vector_shadow,
    input wire logic       proximity_timer_running,
    input wire logic [4:0] ext_irq_event
);
    // ----------------------------------------
    // One clock domain, reset masks all checks
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_shadow_single: assert property (single_vector_shadow |-> !multi_vector_mode)
        else $error("shadow set offered in multi-vector mode");
    a_shadow_on_write: assert property ($changed(single_vector_shadow) |-> $rose(s_axi_bvalid) || $past(sys_rst))
        else $error("shadow output moved without a write");
    a_mode_on_write: assert property ($changed(multi_vector_mode) |-> $rose(s_axi_bvalid) || $past(sys_rst))
        else $error("vector mode moved without a write");
    a_timer_cause: assert property ($rose(proximity_timer_running) |-> $past(core_irq_valid))
        else $error("timer started with no taken interrupt");
    a_event_single: assert property (|ext_irq_event |=> !(|(ext_irq_event & $past(ext_irq_event))))
        else $error("edge event longer than one cycle");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule

bind interrupt_global_control interrupt_global_control_checker chk_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .core_irq_valid(core_irq_valid), .multi_vector_mode(multi_vector_mode),
    .single_vector_shadow(single_vector_shadow),
    .proximity_timer_running(proximity_timer_running), .ext_irq_event(ext_irq_event));

// ===== interrupt_global_control_tb.sv
// Self-checking testbench for the global interrupt control block
`timescale 1ns/1ps
`include "irq_ctl_defines.svh"
module interrupt_global_control_tb;
    typedef struct {logic [11:0] a; irq_ctl_pkg::word_t d; irq_ctl_pkg::word_t v;} row_s;
    logic               ref_clk = 1'b0;
    logic               sys_rst, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata, d, e;
    logic [4:0]         ext_irq_in, ext_irq_event, ev;
    logic [1:0]         bresp, rresp, r;
    logic               awready, wready, bvalid, arready, rvalid, civ, mvm, svs, ptr, irq;
    logic [2:0]         cip;
    int                 n_fail = 0;
    int                 n_checks = 0;
    // Base-register rows: address, data, expected read-back
    row_s rows[6] = '{'{`GCTL_OFS, 32'hffff_ffff, 32'h0001_171f},
        '{`GCTL_CLR_OFS, 32'h0000_1000, 32'h0001_071f},
        '{`GCTL_INV_OFS, 32'h0001_0003, 32'h0000_071c},
        '{`GCTL_SET_OFS, 32'h0001_1001, 32'h0001_171d},
        '{`GCTL_CLR_OFS, 32'hffff_ffff, 32'h0000_0000},
        '{`GCTL_SET_OFS, 32'hfffe_e8e0, 32'h0000_0000}};
    // Timer rows: threshold, priority, should run
    logic [6:0] tt[7] = '{7'h14, 7'h13, 7'h38, 7'h37, 7'h7f, 7'h02, 7'h23};

    always #4 ref_clk = ~ref_clk;

    interrupt_global_control dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_irq_in(ext_irq_in), .core_irq_valid(civ), .core_irq_priority(cip),
        .multi_vector_mode(mvm), .single_vector_shadow(svs),
        .proximity_timer_running(ptr), .ext_irq_event(ext_irq_event), .irq(irq));
    core_vector_model core (.core_irq_valid(civ), .core_irq_priority(cip), .ref_clk(ref_clk));

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // Write: response taken a cycle after it shows, so the hold is exercised
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (bvalid && bready) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
            if (ta && tw && bvalid) bready <= 1'b1;
            if (awvalid && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta;
        ta = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (rvalid && rready) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
            if (ta) rready <= 1'b1;
            if (arvalid && arready) begin
                ta = 1'b1;
                arvalid <= 1'b0;
            end
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: whole run needs several hundred cycles; limit is 20000 cycles
    initial begin
        #160000;
        n_fail++;
        complete_run;
    end

    initial begin
        {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, ext_irq_in} = '0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`GCTL_OFS, d, r);
        chk(d, `GCTL_RESET);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d, r);
            chk({30'h0, r}, {30'h0, `AXI_OKAY});
            rd(`GCTL_OFS, d, r);
            chk(d, rows[k].v);
            chk({31'h0, mvm}, {31'h0, rows[k].v[12]});
            chk({31'h0, svs}, {31'h0, rows[k].v[16] & ~rows[k].v[12]});
        end
        rd(12'h020, d, r);
        chk({30'h0, r}, {30'h0, `AXI_SLVERR});
        wr(12'h020, 32'h0001_171f, r);
        chk({30'h0, r}, {30'h0, `AXI_SLVERR});
        rd(`GCTL_OFS, d, r);
        chk(d, 32'h0000_0000);
        $display("test registers done");
        // Short reload keeps each timer run to a few cycles
        wr(`PTMR_OFS, 32'h0000_0003, r);
        foreach (tt[k]) begin
            wr(`GCTL_OFS, {21'h0, tt[k][6:4], 8'h00}, r);
            core.take(tt[k][3:1], k[1:0]);
            @(posedge ref_clk);
            chk({31'h0, ptr}, {31'h0, tt[k][0]});
            repeat (8) @(posedge ref_clk);
            rd(`ISTAT_OFS, d, r);
            chk(d & 32'h20, {26'h0, tt[k][0], 5'h0});
            wr(`ICLR_OFS, 32'h20, r);
        end
        $display("test proximity timer done");
        // Both polarities, both pin directions; input 2 stays masked
        for (int i = 0; i < 5; i++) begin
            for (int p = 0; p < 2; p++) begin
                wr(`GCTL_OFS, p[0] ? 32'h1f : 32'h0, r);
                wr(`IEN_OFS, (i == 2) ? 32'h0 : 32'h1f, r);
                repeat (2) begin
                    wr(`ICLR_OFS, 32'h3f, r);
                    ext_irq_in[i] <= ~ext_irq_in[i];
                    ev = 5'h00;
                    repeat (6) begin
                        @(posedge ref_clk);
                        ev = ev | ext_irq_event;
                    end
                    e = (ext_irq_in[i] == p[0]) ? (32'h1 << i) : 32'h0;
                    rd(`ISTAT_OFS, d, r);
                    chk(d & 32'h1f, e);
                    chk({27'h0, ev}, e);
                    chk({31'h0, irq}, {31'h0, (e != 0) && (i != 2)});
                end
            end
        end
        $display("test edge polarity done");
        // Reset in mid-run returns the register to zero
        wr(`GCTL_OFS, 32'h0001_0000, r);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`GCTL_OFS, d, r);
        chk(d, `GCTL_RESET);
        chk({31'h0, svs}, 32'h0000_0000);
        $display("test second reset done");
        complete_run;
    end
endmodule
